// [err_tally.v]
// Purpose: Saturating count of errored nibbles during packet self-test
// Assumes: Start pulse and error pulse are synchronous to i_clk
// Notes: Restart wins over a coincident error
`timescale 1ns/1ps
`include "tbt_defs.vh"
module err_tally
#(
   parameter W = 8
)
(
   input wire i_clk, // Core clock
   input wire i_reset, // Sync reset, high
   input wire i_restart, // Self-test started again
   input wire i_err_nibble, // One errored nibble
   output reg [W-1:0] o_count, // Current tally
   output reg o_sat_pulse // Tally just hit maximum
);
   // Count up, clear on restart, stick at maximum
   always @(posedge i_clk)
   begin
      o_sat_pulse <= 1'b0;
      if (i_reset)
      begin
         o_count <= {W{1'b0}};
      end
      else if (i_restart)
      begin
         o_count <= {W{1'b0}};
      end
      else if (i_err_nibble && (o_count != {W{1'b1}}))
      begin
         o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
         o_sat_pulse <= (o_count == {{(W-1){1'b1}}, 1'b0});
      end
   end
endmodule

// [pattern_gen.v]
// Purpose: 10 Mb/s test pattern sequencer with timed idle gap
// Assumes: i_bit_tick marks one 10 MHz bit slot
// Notes: Emits a sequence-start link pulse request for the pulse choice only, then the chosen symbol stream
`timescale 1ns/1ps
`include "tbt_defs.vh"
module pattern_gen
#(
   parameter SEQ_BITS = 64, // Bit slots per data sequence
   parameter GAP_W = 11 // Gap counter width
)
(
   input wire i_clk, // Core clock
   input wire i_reset, // Sync reset, high
   input wire i_enable, // Generator enabled
   input wire i_long_gap, // 15 us gap when high
   input wire [1:0] i_choice, // Pattern select
   input wire i_bit_tick, // One bit slot enable
   output reg o_active, // Pattern drive active
   output reg o_bit, // Pattern bit value
   output reg o_pulse, // Link pulse request
   output reg o_end_b, // End marker form b in use
   output reg o_seq_done // Sequence finished
);
   localparam ST_IDLE = 3'b001;
   localparam ST_SEND = 3'b010;
   localparam ST_GAP = 3'b100;
   reg [2:0] state_reg; // One-hot state
   reg [GAP_W-1:0] gap_reg; // Gap down counter
   reg [7:0] bits_reg; // Bit slots left
   reg [15:0] lfsr_reg; // Data scrambler

   // Gap length from spacing bit
   function [GAP_W-1:0] gap_len;
      input long_gap;
      begin
         gap_len = long_gap ? `GAP_LONG_CYC : `GAP_SHORT_CYC;
      end
   endfunction

   // Sequencer; drops to idle the cycle enable falls
   always @(posedge i_clk)
   begin
      o_seq_done <= 1'b0;
      o_pulse <= 1'b0;
      if (i_reset || !i_enable)
      begin
         state_reg <= ST_IDLE;
         o_active <= 1'b0;
         o_bit <= 1'b0;
         o_end_b <= 1'b0;
         gap_reg <= {GAP_W{1'b0}};
         bits_reg <= 8'h00;
         lfsr_reg <= 16'hACE1;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               state_reg <= ST_SEND;
               o_active <= 1'b1;
               o_end_b <= (i_choice == `SEL_DATA_B);
               o_pulse <= (i_choice == `SEL_PULSES);
               bits_reg <= SEQ_BITS[7:0];
            end
            ST_SEND:
            begin
               if (i_bit_tick)
               begin
                  case (i_choice)
                     `SEL_ONES: o_bit <= 1'b1;
                     `SEL_PULSES: o_bit <= 1'b0;
                     default: o_bit <= lfsr_reg[0];
                  endcase
                  lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[2] ^ lfsr_reg[3] ^ lfsr_reg[5],
                     lfsr_reg[15:1]};
                  bits_reg <= bits_reg - 8'h01;
                  // Constant ones run without a gap
                  if ((bits_reg <= 8'h01 || i_choice == `SEL_PULSES)
                     && i_choice != `SEL_ONES)
                  begin
                     state_reg <= ST_GAP;
                     gap_reg <= gap_len(i_long_gap);
                     o_active <= 1'b0;
                     o_seq_done <= 1'b1;
                  end
               end
            end
            ST_GAP:
            begin
               if (gap_reg <= {{(GAP_W-1){1'b0}}, 1'b1})
                  state_reg <= ST_IDLE;
               else
                  gap_reg <= gap_reg - {{(GAP_W-1){1'b0}}, 1'b1};
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// [tbt_checker_assertions.sv]
// Purpose: Port checks for the line config and pattern block
// Assumes: One clock, sync high reset
// Notes: Sees top module ports only
`timescale 1ns/1ps
`include "tbt_defs.vh"
module tbt_checker
(
   input logic i_clk, // Clock
   input logic i_reset, // Reset
   input logic [4:0] i_addr, // Address
   input logic [15:0] i_wdata, // Write data
   input logic i_wr, // Write
   input logic i_rd, // Read
   input logic [15:0] o_rdata, // Read data
   input logic i_speed_100, // Fast link
   input logic i_full_duplex, // Full duplex
   input logic i_selftest_on, // Self-test on
   input logic i_selftest_start, // Restart
   input logic i_err_nibble, // Bad nibble
   input logic o_heartbeat_en, // Heartbeat
   input logic o_long_tx_guard_en, // Guard
   input logic o_nonstop_tx, // Nonstop
   input logic o_pat_active // Pattern drive
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // Config write in half-duplex 10M, then mode held
   sequence s_cfg_wr;
      i_wr && i_addr == `ADDR_LINE_CFG && !i_speed_100 && !i_full_duplex;
   endsequence
   sequence s_half10;
      (!i_speed_100 && !i_full_duplex)[*2];
   endsequence
   // Restart, two clean cycles, tally read in the second clean cycle
   sequence s_restart_rd;
      i_selftest_start ##1 (!i_err_nibble)[*2] ##0 (i_rd && i_addr == `ADDR_PAT_EXT);
   endsequence
   property p_hb_follow;
      s_cfg_wr ##1 s_half10 |-> o_heartbeat_en == !$past(i_wdata[1], 2);
   endproperty
   a_hb_follow: assert property (p_hb_follow) else $error("heartbeat bit ignored");
   property p_hb_forced;
      (i_speed_100 || i_full_duplex) |=> !o_heartbeat_en;
   endproperty
   a_hb_forced: assert property (p_hb_forced) else $error("heartbeat not forced off");
   property p_guard_follow;
      s_cfg_wr ##1 s_half10 |-> o_long_tx_guard_en == !$past(i_wdata[0], 2);
   endproperty
   a_guard_follow: assert property (p_guard_follow) else $error("guard bit ignored");
   property p_guard_100;
      i_speed_100 |=> !o_long_tx_guard_en;
   endproperty
   a_guard_100: assert property (p_guard_100) else $error("guard active at 100M");
   property p_restart_clear;
      s_restart_rd |=> o_rdata[15:8] == 8'h00;
   endproperty
   a_restart_clear: assert property (p_restart_clear) else $error("tally not cleared");
   property p_nonstop_gate;
      !i_selftest_on |=> !o_nonstop_tx;
   endproperty
   a_nonstop_gate: assert property (p_nonstop_gate) else $error("nonstop without self-test");
   property p_pat_off_100;
      i_speed_100[*3] |-> !o_pat_active;
   endproperty
   a_pat_off_100: assert property (p_pat_off_100) else $error("pattern at 100M");
   property p_rdata_idle;
      !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_unmapped;
      i_rd && i_addr == 5'h00 |=> o_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// [tbt_defs.vh]
// Purpose: Constants for the 10 Mb/s line config and test pattern block
// Assumes: 100 MHz core clock
// Notes: Register indexes are management register numbers
`ifndef TBT_DEFS_VH
`define TBT_DEFS_VH
`define ADDR_W 5
`define ADDR_LINE_CFG 5'h1A
`define ADDR_PAT_EXT 5'h1B
`define ADDR_IRQ_STAT 5'h1C
`define ADDR_IRQ_CLR 5'h1E
`define ADDR_IRQ_EN 5'h1F
`define LINE_CFG_RESET 16'h0904
`define LINE_CFG_WMASK 16'hFFE3
`define PAT_EXT_WMASK 8'hFF
`define BIT_HB_OFF 1
`define BIT_GUARD_OFF 0
`define BIT_NONSTOP 5
`define BIT_PAT_ON 4
`define BIT_SPACING 2
`define PAT_SEL_LO 0
`define CLK_MHZ 100
`define GAP_SHORT_US 10
`define GAP_LONG_US 15
`define GAP_SHORT_CYC (`GAP_SHORT_US * `CLK_MHZ)
`define GAP_LONG_CYC (`GAP_LONG_US * `CLK_MHZ)
`define SEL_DATA_A 2'h0
`define SEL_DATA_B 2'h1
`define SEL_PULSES 2'h2
`define SEL_ONES 2'h3
`define ERR_MAX 8'hFF
`define IRQ_W 3
`define IRQ_SAT 0
`define IRQ_SEQ 1
`define IRQ_START 2
`endif

// [tenbase_test_pattern_bist_ctrl.v]
// Purpose: Line config and test-pattern control, management registers
// Assumes: Speed, duplex and self-test status come from the core
// Notes: Interrupt status sticky; set wins over clear
`timescale 1ns/1ps
`include "tbt_defs.vh"
module tenbase_test_pattern_bist_ctrl
#(
   parameter ERR_W = 8, // Tally width
   parameter SEQ_BITS = 64, // Bit slots per pattern sequence
   parameter BIT_DIV = 10 // Core cycles per 10 MHz bit slot
)
(
   input wire i_clk, // Core clock, 100 MHz
   input wire i_reset, // Sync reset, high
   input wire [`ADDR_W-1:0] i_addr, // Register address
   input wire [15:0] i_wdata, // Write data
   input wire i_wr, // Write strobe
   input wire i_rd, // Read strobe
   output reg [15:0] o_rdata, // Read data, cycle after strobe
   input wire i_speed_100, // Link runs at 100 Mb/s
   input wire i_full_duplex, // Link in full duplex
   input wire i_selftest_on, // Packet self-test running
   input wire i_selftest_start, // Self-test start pulse
   input wire i_err_nibble, // Errored nibble pulse
   output reg o_heartbeat_en, // Heartbeat function active
   output reg o_long_tx_guard_en, // Jabber guard active
   output reg o_nonstop_tx, // Gapless pseudo-random transmit
   output reg o_pat_active, // Pattern drive active
   output reg o_pat_bit, // Pattern bit value
   output reg o_pat_pulse, // Link pulse request
   output reg o_pat_end_b, // End marker form b
   output reg o_irq // Interrupt, level high
);
   reg [15:0] line_cfg_reg; // Line configuration word
   reg [7:0] pat_ext_reg; // Low byte of test extension
   reg [`IRQ_W-1:0] irq_stat_reg; // Sticky event bits
   reg [`IRQ_W-1:0] irq_stat_next; // Next sticky bits
   reg [`IRQ_W-1:0] irq_en_reg; // Interrupt enables
   reg [3:0] div_reg; // Bit slot divider
   reg bit_tick_reg; // One-cycle bit slot pulse
   reg [15:0] rd_next; // Read mux result
   wire [ERR_W-1:0] tally; // selftest_err_tally
   wire sat_pulse; // Tally reached maximum
   wire pat_active; // Generator outputs
   wire pat_bit;
   wire pat_pulse;
   wire pat_end_b;
   wire seq_done;

   // Named field views
   wire heartbeat_off = line_cfg_reg[`BIT_HB_OFF];
   wire long_tx_guard_off = line_cfg_reg[`BIT_GUARD_OFF];
   wire selftest_nonstop_tx = pat_ext_reg[`BIT_NONSTOP];
   wire ten_pattern_on = pat_ext_reg[`BIT_PAT_ON];
   wire ten_pattern_spacing = pat_ext_reg[`BIT_SPACING];
   wire [1:0] ten_pattern_choice = pat_ext_reg[`PAT_SEL_LO +: 2];

   // Register writes; read-only bits are masked out
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         line_cfg_reg <= `LINE_CFG_RESET;
         pat_ext_reg <= 8'h00;
         irq_en_reg <= {`IRQ_W{1'b0}};
      end
      else if (i_wr)
      begin
         case (i_addr)
            `ADDR_LINE_CFG:
               line_cfg_reg <= (i_wdata & `LINE_CFG_WMASK) | (line_cfg_reg & ~`LINE_CFG_WMASK);
            `ADDR_PAT_EXT:
               pat_ext_reg <= i_wdata[7:0] & `PAT_EXT_WMASK;
            `ADDR_IRQ_EN:
               irq_en_reg <= i_wdata[`IRQ_W-1:0];
            default:
            begin
               // Unmapped writes ignored
            end
         endcase
      end
   end

   // Read mux; unmapped reads return zero
   always @*
   begin
      rd_next = 16'h0000;
      case (i_addr)
         `ADDR_LINE_CFG: rd_next = line_cfg_reg;
         `ADDR_PAT_EXT: rd_next = {tally, pat_ext_reg};
         `ADDR_IRQ_STAT: rd_next = {{(16-`IRQ_W){1'b0}}, irq_stat_reg};
         default: rd_next = 16'h0000;
      endcase
   end

   // Registered read data, one cycle later only
   always @(posedge i_clk)
   begin
      if (i_reset)
         o_rdata <= 16'h0000;
      else if (i_rd)
         o_rdata <= rd_next;
      else
         o_rdata <= 16'h0000;
   end

   // Sticky events; a set in the clear cycle survives
   always @*
   begin
      irq_stat_next = irq_stat_reg;
      if (i_wr && i_addr == `ADDR_IRQ_CLR)
         irq_stat_next = irq_stat_next & ~i_wdata[`IRQ_W-1:0];
      if (sat_pulse)
         irq_stat_next[`IRQ_SAT] = 1'b1;
      if (seq_done)
         irq_stat_next[`IRQ_SEQ] = 1'b1;
      if (i_selftest_start)
         irq_stat_next[`IRQ_START] = 1'b1;
   end

   // Status and interrupt output
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         irq_stat_reg <= {`IRQ_W{1'b0}};
         o_irq <= 1'b0;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
         o_irq <= |(irq_stat_next & irq_en_reg);
      end
   end

   // Bit slot divider; free running keeps slot timing simple
   always @(posedge i_clk)
   begin
      if (i_reset || div_reg == BIT_DIV[3:0] - 4'h1)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
      bit_tick_reg <= !i_reset && (div_reg == BIT_DIV[3:0] - 4'h1);
   end

   // Line function enables
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_heartbeat_en <= 1'b0;
         o_long_tx_guard_en <= 1'b0;
         o_nonstop_tx <= 1'b0;
      end
      else
      begin
         // heartbeat per bit in half 10M
         // forced off at 100M or full
         o_heartbeat_en <= !heartbeat_off && !i_speed_100 && !i_full_duplex;
         o_long_tx_guard_en <= !long_tx_guard_off && !i_speed_100;
         o_nonstop_tx <= selftest_nonstop_tx && i_selftest_on;
      end
   end

   // Pattern outputs registered at top
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_pat_active <= 1'b0;
         o_pat_bit <= 1'b0;
         o_pat_pulse <= 1'b0;
         o_pat_end_b <= 1'b0;
      end
      else
      begin
         o_pat_active <= pat_active;
         o_pat_bit <= pat_bit;
         o_pat_pulse <= pat_pulse;
         o_pat_end_b <= pat_end_b;
      end
   end

   // Errored nibble tally
   err_tally #(.W(ERR_W)) u_tally
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_restart(i_selftest_start),
      .i_err_nibble(i_err_nibble && i_selftest_on),
      .o_count(tally),
      .o_sat_pulse(sat_pulse)
   );

   pattern_gen #(.SEQ_BITS(SEQ_BITS)) u_pat
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_enable(ten_pattern_on && !i_speed_100),
      .i_long_gap(ten_pattern_spacing),
      .i_choice(ten_pattern_choice),
      .i_bit_tick(bit_tick_reg),
      .o_active(pat_active),
      .o_bit(pat_bit),
      .o_pulse(pat_pulse),
      .o_end_b(pat_end_b),
      .o_seq_done(seq_done)
   );
endmodule

// [tenbase_test_pattern_bist_ctrl_bench.sv]
// Purpose: Self-checking bench for the line config and pattern block
// Assumes: Short pattern sequences via parameter
// Notes: Each scenario task judges its own results
`timescale 1ns/1ps
`include "tbt_defs.vh"
module tenbase_test_pattern_bist_ctrl_bench;
   logic i_clk = 1'h0;
   logic i_reset = 1'h1;
   logic i_wr = 1'h0;
   logic i_rd = 1'h0;
   logic [4:0] i_addr = 5'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_speed_100 = 1'h0;
   logic i_full_duplex = 1'h0;
   logic i_selftest_on = 1'h0;
   logic i_selftest_start = 1'h0;
   logic i_err_nibble = 1'h0;
   wire [15:0] o_rdata;
   wire o_heartbeat_en, o_long_tx_guard_en, o_nonstop_tx, o_irq;
   wire o_pat_active, o_pat_bit, o_pat_pulse, o_pat_end_b;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   initial forever #5 i_clk = ~i_clk;
   tenbase_test_pattern_bist_ctrl #(.SEQ_BITS(4)) tenbase_test_pattern_bist_ctrl_i (.i_clk,
      .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_speed_100, .i_full_duplex,
      .i_selftest_on, .i_selftest_start, .i_err_nibble, .o_heartbeat_en, .o_long_tx_guard_en,
      .o_nonstop_tx, .o_pat_active, .o_pat_bit, .o_pat_pulse, .o_pat_end_b, .o_irq);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle strobes, changed only after an edge
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 chk(o_rdata, exp);
   endtask
   task t_regs;
      rd(`ADDR_LINE_CFG, 16'h0904);
      rd(`ADDR_PAT_EXT, 16'h0000);
      // Bits 4..2 keep their value against writes
      wr(`ADDR_LINE_CFG, 16'hFFFF);
      rd(`ADDR_LINE_CFG, 16'hFFE7);
      wr(`ADDR_PAT_EXT, 16'hFFFF);
      rd(`ADDR_PAT_EXT, 16'h00FF);
      wr(`ADDR_PAT_EXT, 16'h0000);
      rd(5'h00, 16'h0000);
      rd(`ADDR_IRQ_CLR, 16'h0000);
   endtask
   // Every mix of disable bit, speed and duplex
   task t_line;
      for (int i = 0; i < 8; i++)
      begin
         wr(`ADDR_LINE_CFG, {14'h0000, i[0], i[0]});
         i_speed_100 <= i[1];
         i_full_duplex <= i[2];
         repeat (3) @(posedge i_clk);
         #1 chk(o_heartbeat_en, !i[0] && !i[1] && !i[2]);
         chk(o_long_tx_guard_en, !i[0] && !i[1]);
      end
      i_speed_100 <= 1'h0;
      i_full_duplex <= 1'h0;
   endtask
   task err_pulses(input int k);
      repeat (k)
      begin
         @(posedge i_clk);
         i_err_nibble <= 1'h1;
         @(posedge i_clk);
         i_err_nibble <= 1'h0;
      end
   endtask
   task restart;
      @(posedge i_clk);
      i_selftest_on <= 1'h1;
      i_selftest_start <= 1'h1;
      @(posedge i_clk);
      i_selftest_start <= 1'h0;
   endtask
   task t_tally;
      wr(`ADDR_IRQ_CLR, 16'h0007);
      restart();
      err_pulses(3);
      rd(`ADDR_PAT_EXT, 16'h0300);
      // Far past the top to catch a wrap
      err_pulses(260);
      rd(`ADDR_PAT_EXT, 16'hFF00);
      rd(`ADDR_IRQ_STAT, 16'h0005);
      wr(`ADDR_IRQ_EN, 16'h0001);
      @(posedge i_clk);
      #1 chk(o_irq, 1'h1);
      wr(`ADDR_IRQ_CLR, 16'h0001);
      @(posedge i_clk);
      #1 chk(o_irq, 1'h0);
      restart();
      rd(`ADDR_PAT_EXT, 16'h0000);
   endtask
   task t_nonstop;
      wr(`ADDR_LINE_CFG, 16'h0001);
      wr(`ADDR_PAT_EXT, 16'h0020);
      repeat (2) @(posedge i_clk);
      #1 chk(o_nonstop_tx, 1'h1);
      @(posedge i_clk);
      i_selftest_on <= 1'h0;
      repeat (2) @(posedge i_clk);
      #1 chk(o_nonstop_tx, 1'h0);
      wr(`ADDR_PAT_EXT, 16'h0000);
   endtask
   // Cycles from one link pulse to the next
   task gap_meas(output int p);
      for (p = 0; p < 4000 && o_pat_pulse !== 1'h1; p++)
      begin
         @(posedge i_clk);
         #1;
      end
      p = 0;
      do
      begin
         @(posedge i_clk);
         #1 p++;
      end
      while (o_pat_pulse !== 1'h1 && p < 4000);
   endtask
   // Cycles over len where the drive differs from want
   task hold_cnt(input logic want, input int len, output int p);
      p = 0;
      repeat (len)
      begin
         @(posedge i_clk);
         #1 if (o_pat_active !== want || (want && o_pat_bit !== 1'h1)) p++;
      end
   endtask
   task t_pattern;
      wr(`ADDR_PAT_EXT, 16'h0012);
      gap_meas(n);
      chk(n >= 1000 && n <= 1030, 1'h1);
      wr(`ADDR_PAT_EXT, 16'h0016);
      gap_meas(n);
      chk(n >= 1500 && n <= 1530, 1'h1);
      rd(`ADDR_IRQ_STAT, 16'h0006);
      // Drop the generator first so a running gap does not delay the ones
      wr(`ADDR_PAT_EXT, 16'h0000);
      wr(`ADDR_PAT_EXT, 16'h0013);
      repeat (50) @(posedge i_clk);
      hold_cnt(1'h1, 2000, n);
      chk(n, 16'h0000);
      for (int c = 0; c < 2; c++)
      begin
         wr(`ADDR_PAT_EXT, 16'h0010 | c);
         repeat (1100) @(posedge i_clk);
         for (n = 0; n < 2000 && o_pat_active !== 1'h1; n++) @(posedge i_clk);
         #1 chk(o_pat_end_b, c[0]);
      end
      // Gap and choice set, generator off
      wr(`ADDR_PAT_EXT, 16'h0007);
      repeat (3) @(posedge i_clk);
      hold_cnt(1'h0, 3000, n);
      chk(n, 16'h0000);
   endtask
   task final_report;
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         $display("mismatch at %0t: timeout", $time);
         final_report();
      end
   end
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_reset <= 1'h0;
      t_regs();
      t_line();
      t_tally();
      t_nonstop();
      t_pattern();
      final_report();
   end
endmodule
bind tenbase_test_pattern_bist_ctrl tbt_checker tbt_checker_i (.i_clk, .i_reset, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .i_speed_100, .i_full_duplex, .i_selftest_on,
   .i_selftest_start, .i_err_nibble, .o_heartbeat_en, .o_long_tx_guard_en, .o_nonstop_tx,
   .o_pat_active);
